// file: hdl/pdc_clock_gate.sv
// Glitch-free clock gate for one on-chip unit.
// Assumes the enable comes from logic on the rising edge of clk.
`timescale 1ns/1ps
module pdc_clock_gate import pdc_pkg::*; (
    input wire logic clk, // Free-running clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic enable, // Run request, sampled on the falling edge
    output logic gclk // Gated clock
);
    logic en_low_reg;

    // ==========================================================
    // Enable retimed on the falling edge
    // ==========================================================
    // Changing the enable only while clk is low means the AND below can
    // never cut a high phase short.
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_low_reg <= 1'b1;
        end else begin
            en_low_reg <= enable;
        end
    end

    assign gclk = clk & en_low_reg;
endmodule

// file: hdl/pdc_pkg.sv
// Package for the power-down control block: register map, field layout,
// reset values and the carrier types shared by the design files.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package pdc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] PDC_ADDR_STANDBY_CONTROL = 8'h00;
    localparam logic [7:0] PDC_ADDR_MODULE_CLOCK_STOP_A = 8'h04;
    localparam logic [7:0] PDC_ADDR_POWER_STATUS = 8'h08;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PDC_BIT_STANDBY_SELECT = 7;
    localparam int PDC_BIT_MODE_PIN_APPLY = 3;
    localparam int PDC_BIT_DEBUG_PORT_CLOCK_STOP = 7;
    localparam int PDC_BIT_BREAK_UNIT_CLOCK_STOP = 6;
    localparam int PDC_BIT_CACHE_CLOCK_STOP = 2;
    localparam int PDC_BIT_USER_MEMORY_CLOCK_STOP = 1;

    // Writable bits of each register; all others read as zero
    localparam logic [7:0] PDC_MASK_STANDBY_CONTROL = 8'h88;
    localparam logic [7:0] PDC_MASK_MODULE_CLOCK_STOP_A = 8'hc6;

    // Status register: [1:0] power state, [6:4] applied mode value
    localparam int PDC_POS_STATE = 0;
    localparam int PDC_POS_MODE_VALUE = 4;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] PDC_RST_STANDBY_CONTROL = 8'h00;
    localparam logic [7:0] PDC_RST_MODULE_CLOCK_STOP_A = 8'h00;
    localparam logic [2:0] PDC_RST_MODE_VALUE = 3'h0;

    // Number of gated unit clocks and mode-select pins
    localparam int PDC_NUM_GATES = 4;
    localparam int PDC_MODE_PINS = 3;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        PDC_RUN = 2'b00,
        PDC_SLEEP = 2'b01,
        PDC_STANDBY = 2'b10
    } pdc_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } pdc_wb_req_t;

endpackage

// file: hdl/pdc_power_down_ctrl.sv
// Power-down control: standby select, mode-pin apply on standby wake-up and
// per-unit clock stops, reached over a classic Wishbone slave.
// Assumes the CPU core and interrupt logic share CLK; mode pins are async.
`timescale 1ns/1ps

// Functional notes
// - Both registers 8-bit, read/write, reset zero.
// - Bit7 picks sleep or software standby.
// - Bit3 applies mode pins on standby wake.
// - First register reserved bits read zero.
// - Bit7 second register halts debug clock.
// - Bit6 second register halts break clock.
// - Bit2 second register halts cache clock.
// - Bit1 second register halts user-memory clock.
// - Second register reserved bits read zero.
// - Standby halts all; sleep halts CPU only.
module pdc_power_down_ctrl import pdc_pkg::*; (
    input wire logic CLK, // System clock, 200 MHz
    input wire logic RESETN, // Asynchronous reset, active low
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write enable
    input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
    input wire logic [7:0] WB_ADR_I, // Wishbone byte address
    input wire logic [31:0] WB_DAT_I, // Wishbone write data
    output logic [31:0] WB_DAT_O, // Wishbone read data
    output logic WB_ACK_O, // Wishbone acknowledge
    input wire logic SLEEP_EXEC, // CPU executes sleep instruction, pulse
    input wire logic WAKE_INT, // Interrupt that cancels a power-down mode
    input wire logic [2:0] MODE_SELECT_PINS, // Mode-select pins, async
    output logic [2:0] MODE_VALUE, // Mode value in effect
    output logic CPU_HALT, // CPU halted (sleep or standby)
    output logic CLOCK_HALT, // Clock generator halted (standby)
    output logic PERIPH_HALT, // On-chip peripherals halted (standby)
    output logic DEBUG_INTERFACE_UNIT_CLK, // Gated clock, debug interface unit
    output logic USER_BREAK_UNIT_CLK, // Gated clock, user break unit
    output logic CACHE_CLK, // Gated clock, cache memory
    output logic USER_MEMORY_CLK // Gated clock, user memory
);

    // ==========================================================
    // Bus request carrier
    // ==========================================================
    pdc_wb_req_t req;

    assign req.cyc = WB_CYC_I;
    assign req.stb = WB_STB_I;
    assign req.we = WB_WE_I;
    assign req.sel = WB_SEL_I;
    assign req.adr = WB_ADR_I;
    assign req.dat = WB_DAT_I;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] standby_control_reg;
    logic [7:0] standby_control_next;
    logic [7:0] module_clock_stop_a_reg;
    logic [7:0] module_clock_stop_a_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    pdc_state_t state_reg;
    pdc_state_t state_next;
    logic [2:0] mode_value_reg;
    logic [2:0] mode_value_next;
    logic boot_done_reg;
    logic cpu_halt_reg;
    logic clock_halt_reg;
    logic periph_halt_reg;

    // ==========================================================
    // Mode pin synchroniser
    // ==========================================================
    // The pins are asynchronous, so two flops stand before any logic reads them.
    logic [2:0] mode_pins_sync;

    pdc_sync #(
        .WIDTH(PDC_MODE_PINS)
    ) u_mode_sync (
        .clk(CLK),
        .rst_n(RESETN),
        .d(MODE_SELECT_PINS),
        .q(mode_pins_sync)
    );

    // ==========================================================
    // Address decode
    // ==========================================================
    wire access = req.cyc & req.stb & ~ack_reg;
    wire byte0_wr = access & req.we & req.sel[0];
    wire hit_standby_control = (req.adr == PDC_ADDR_STANDBY_CONTROL);
    wire hit_module_clock_stop_a = (req.adr == PDC_ADDR_MODULE_CLOCK_STOP_A);
    wire hit_power_status = (req.adr == PDC_ADDR_POWER_STATUS);
    wire wr_standby_control = byte0_wr & hit_standby_control;
    wire wr_module_clock_stop_a = byte0_wr & hit_module_clock_stop_a;

    // Reserved bits are masked at write time so they always read zero.
    assign standby_control_next = wr_standby_control ?
        (req.dat[7:0] & PDC_MASK_STANDBY_CONTROL) : standby_control_reg;
    assign module_clock_stop_a_next = wr_module_clock_stop_a ?
        (req.dat[7:0] & PDC_MASK_MODULE_CLOCK_STOP_A) : module_clock_stop_a_reg;

    wire [31:0] status_word = {24'h000000, 1'b0, mode_value_reg, 2'b00, state_reg};

    wire [31:0] standby_control_word = {24'h000000, standby_control_reg};
    wire [31:0] module_clock_stop_a_word = {24'h000000, module_clock_stop_a_reg};
    logic [31:0] rdata_sel;

    // Unmapped addresses are acknowledged with zero data; writes there vanish.
    always_comb begin
        if (hit_standby_control) begin
            rdata_sel = standby_control_word;
        end else if (hit_module_clock_stop_a) begin
            rdata_sel = module_clock_stop_a_word;
        end else if (hit_power_status) begin
            rdata_sel = status_word;
        end else begin
            rdata_sel = 32'h00000000;
        end
    end

    // ==========================================================
    // Register file
    // ==========================================================
    // Only byte lane 0 carries the registers; the other lanes are ignored.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            standby_control_reg <= PDC_RST_STANDBY_CONTROL;
        end else begin
            standby_control_reg <= standby_control_next;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            module_clock_stop_a_reg <= PDC_RST_MODULE_CLOCK_STOP_A;
        end else begin
            module_clock_stop_a_reg <= module_clock_stop_a_next;
        end
    end

    // ==========================================================
    // Bus answer
    // ==========================================================
    // The ack term in access keeps a strobe that is still held in the ack
    // cycle from being taken a second time.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    // Read data is zero outside the ack cycle, so a stale word never shows.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= access ? rdata_sel : 32'h00000000;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;

    // ==========================================================
    // Power state machine
    // ==========================================================
    wire standby_select = standby_control_reg[PDC_BIT_STANDBY_SELECT];
    wire mode_pin_apply = standby_control_reg[PDC_BIT_MODE_PIN_APPLY];

    // A sleep pulse outside RUN and a wake pulse in RUN fall through unused.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PDC_RUN: begin
                if (SLEEP_EXEC) begin
                    state_next = standby_select ? PDC_STANDBY : PDC_SLEEP;
                end
            end
            PDC_SLEEP: begin
                if (WAKE_INT) begin
                    state_next = PDC_RUN;
                end
            end
            PDC_STANDBY: begin
                if (WAKE_INT) begin
                    state_next = PDC_RUN;
                end
            end
            default: begin
                state_next = PDC_RUN;
            end
        endcase
    end

    // Mode value is caught once after reset release, then only on an
    // interrupt wake-up from software standby with the apply bit set.
    wire standby_wake = (state_reg == PDC_STANDBY) & WAKE_INT;

    assign mode_value_next =
        !boot_done_reg ? mode_pins_sync :
        (standby_wake & mode_pin_apply) ? mode_pins_sync :
        mode_value_reg;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= PDC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_value_reg <= PDC_RST_MODE_VALUE;
        end else begin
            mode_value_reg <= mode_value_next;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            boot_done_reg <= 1'b0;
        end else begin
            boot_done_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Halt outputs
    // ==========================================================
    // Sleep stops only the CPU; standby also stops clock and peripherals.
    wire in_sleep_next = (state_next == PDC_SLEEP);
    wire in_standby_next = (state_next == PDC_STANDBY);

    // Each halt is registered from the next state so it moves with the state.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cpu_halt_reg <= 1'b0;
        end else begin
            cpu_halt_reg <= in_sleep_next | in_standby_next;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            clock_halt_reg <= 1'b0;
        end else begin
            clock_halt_reg <= in_standby_next;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            periph_halt_reg <= 1'b0;
        end else begin
            periph_halt_reg <= in_standby_next;
        end
    end

    assign CPU_HALT = cpu_halt_reg;
    assign CLOCK_HALT = clock_halt_reg;
    assign PERIPH_HALT = periph_halt_reg;
    assign MODE_VALUE = mode_value_reg;

    // ==========================================================
    // Unit clock gates
    // ==========================================================
    // Gate order: debug interface, user break, cache, user memory.
    // A unit runs while its stop bit is 0 and the chip is not in standby.
    logic [PDC_NUM_GATES-1:0] stop_bits;
    logic [PDC_NUM_GATES-1:0] gate_enable;
    logic [PDC_NUM_GATES-1:0] gate_clk;

    assign stop_bits[0] = module_clock_stop_a_reg[PDC_BIT_DEBUG_PORT_CLOCK_STOP];
    assign stop_bits[1] = module_clock_stop_a_reg[PDC_BIT_BREAK_UNIT_CLOCK_STOP];
    assign stop_bits[2] = module_clock_stop_a_reg[PDC_BIT_CACHE_CLOCK_STOP];
    assign stop_bits[3] = module_clock_stop_a_reg[PDC_BIT_USER_MEMORY_CLOCK_STOP];

    assign gate_enable = ~stop_bits & {PDC_NUM_GATES{~clock_halt_reg}};

    genvar gi;
    generate
        for (gi = 0; gi < PDC_NUM_GATES; gi = gi + 1) begin : g_gate
            pdc_clock_gate u_gate (
                .clk(CLK),
                .rst_n(RESETN),
                .enable(gate_enable[gi]),
                .gclk(gate_clk[gi])
            );
        end
    endgenerate

    // Gated clocks cannot come from a flop; they come from the glitch-free gate.
    assign DEBUG_INTERFACE_UNIT_CLK = gate_clk[0];
    assign USER_BREAK_UNIT_CLK = gate_clk[1];
    assign CACHE_CLK = gate_clk[2];
    assign USER_MEMORY_CLK = gate_clk[3];

endmodule

// file: hdl/pdc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes the inputs change slowly compared with the clock.
`timescale 1ns/1ps
module pdc_sync import pdc_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d, // Asynchronous input
    output logic [WIDTH-1:0] q // Synchronised output
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // ==========================================================
    // First stage is read only by the second
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

// file: tb/pdc_power_down_ctrl_assertions.sv
// Checker for the power-down control block: bus answer and halt outputs.
// Assumes a master that holds each request until it sees ack.
`timescale 1ns/1ps
module pdc_power_down_ctrl_assertions import pdc_pkg::*; (
    input wire logic CLK, // System clock
    input wire logic RESETN, // Reset, active low
    input wire logic WB_CYC_I, // Cycle
    input wire logic WB_STB_I, // Strobe
    input wire logic WB_WE_I, // Write enable
    input wire logic [3:0] WB_SEL_I, // Byte selects
    input wire logic [7:0] WB_ADR_I, // Address
    input wire logic [31:0] WB_DAT_I, // Write data
    input wire logic [31:0] WB_DAT_O, // Read data
    input wire logic WB_ACK_O, // Acknowledge
    input wire logic SLEEP_EXEC, // Sleep instruction
    input wire logic WAKE_INT, // Wake interrupt
    input wire logic [2:0] MODE_VALUE, // Mode value
    input wire logic CPU_HALT, // CPU halted
    input wire logic CLOCK_HALT, // Clock halted
    input wire logic PERIPH_HALT // Peripherals halted
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // ==========================================
    // Shadow of the standby select bit, which is not at the ports
    logic standby_select_reg;
    wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire wr0 = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == PDC_ADDR_STANDBY_CONTROL;
    wire rd_ack = WB_ACK_O && !WB_WE_I;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) standby_select_reg <= 1'b0;
        else if (wr0) standby_select_reg <= WB_DAT_I[PDC_BIT_STANDBY_SELECT];
    end
    property p_ack; take |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack late or long");
    property p_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data outside ack");
    property p_resv0;
        rd_ack && WB_ADR_I == PDC_ADDR_STANDBY_CONTROL |-> WB_DAT_O[6:4] == 3'h0
            && WB_DAT_O[2:0] == 3'h0 && WB_DAT_O[31:8] == 24'h0;
    endproperty
    a_resv0: assert property (p_resv0) else $error("reserved set in reg0");
    property p_resv1;
        rd_ack && WB_ADR_I == PDC_ADDR_MODULE_CLOCK_STOP_A |-> WB_DAT_O[5:3] == 3'h0
            && !WB_DAT_O[0] && WB_DAT_O[31:8] == 24'h0;
    endproperty
    a_resv1: assert property (p_resv1) else $error("reserved set in reg1");
    property p_sleep;
        SLEEP_EXEC && !CPU_HALT |=> CPU_HALT && CLOCK_HALT == $past(standby_select_reg)
            && PERIPH_HALT == $past(standby_select_reg);
    endproperty
    a_sleep: assert property (p_sleep) else $error("wrong power mode");
    property p_wake; WAKE_INT && CPU_HALT |=> !CPU_HALT && !CLOCK_HALT && !PERIPH_HALT; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_hold;
        CPU_HALT && !WAKE_INT |=> CPU_HALT && $stable(CLOCK_HALT) && PERIPH_HALT == CLOCK_HALT;
    endproperty
    a_hold: assert property (p_hold) else $error("halt not held");
    property p_run; !CPU_HALT && !SLEEP_EXEC |=> !CPU_HALT && !CLOCK_HALT; endproperty
    a_run: assert property (p_run) else $error("halt without sleep");
    property p_mode; !(WAKE_INT && CLOCK_HALT) |=> $stable(MODE_VALUE); endproperty
    a_mode: assert property (p_mode) else $error("mode value moved");
    c_sleep: cover property (SLEEP_EXEC && !CPU_HALT && !standby_select_reg);
    c_standby: cover property (SLEEP_EXEC && !CPU_HALT && standby_select_reg);
    c_read: cover property (rd_ack);
endmodule

bind pdc_power_down_ctrl pdc_power_down_ctrl_assertions i_pdc_power_down_ctrl_assertions (
    .CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_SEL_I, .WB_ADR_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .SLEEP_EXEC, .WAKE_INT, .MODE_VALUE, .CPU_HALT, .CLOCK_HALT,
    .PERIPH_HALT);

// file: tb/pdc_unit_model.sv
// Model of the four gated units: counts clock edges, flags short pulses.
// Assumes gclk bits are debug, break, cache, user memory from 3 to 0.
`timescale 1ns/1ps
module pdc_unit_model import pdc_pkg::*; (
    input wire logic [PDC_NUM_GATES-1:0] gclk, // Unit clocks
    output int edges [PDC_NUM_GATES], // Rising edges per unit
    output int glitches [PDC_NUM_GATES] // Short high phases per unit
);
    // ==========================================
    // Per-unit observers
    realtime rise_t [PDC_NUM_GATES];
    for (genvar g = 0; g < PDC_NUM_GATES; g++) begin : g_unit
        always @(posedge gclk[g]) begin
            edges[g] <= edges[g] + 1;
            rise_t[g] = $realtime;
        end
        // Half a period is 2.5 ns; anything under 2.4 ns is a gate glitch
        always @(negedge gclk[g]) begin
            if ($realtime - rise_t[g] < 2.4) glitches[g] <= glitches[g] + 1;
        end
    end
endmodule

// file: tb/power_down_mode_clock_gating_tb.sv
// Testbench for the power-down control block: registers, modes, gates.
// Assumes the checker is bound to the design and the unit model beside it.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %0t: got %0h want %0h", $time, (a), (e)); end end
module power_down_mode_clock_gating_tb import pdc_pkg::*; ;
    localparam logic [7:0] A0 = PDC_ADDR_STANDBY_CONTROL;
    localparam logic [7:0] A1 = PDC_ADDR_MODULE_CLOCK_STOP_A;
    localparam int GBIT [PDC_NUM_GATES] = '{1, 2, 6, 7};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    pdc_wb_req_t req = '0;
    logic sleep_exec = 1'b0;
    logic wake_int = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [31:0] dat_o, q, r;
    logic ack, cpu_halt, clock_halt, periph_halt;
    logic [2:0] mode_value, mv;
    wire [3:0] gclk;
    logic [7:0] d, a;
    logic [31:0] seed = 32'hc593;
    int edges [PDC_NUM_GATES];
    int glitches [PDC_NUM_GATES];
    int fail_count = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    pdc_power_down_ctrl i_pdc_power_down_ctrl (.CLK(clk), .RESETN(resetn),
        .WB_CYC_I(req.cyc), .WB_STB_I(req.stb), .WB_WE_I(req.we), .WB_SEL_I(req.sel),
        .WB_ADR_I(req.adr), .WB_DAT_I(req.dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .SLEEP_EXEC(sleep_exec), .WAKE_INT(wake_int), .MODE_SELECT_PINS(pins),
        .MODE_VALUE(mode_value), .CPU_HALT(cpu_halt), .CLOCK_HALT(clock_halt),
        .PERIPH_HALT(periph_halt), .DEBUG_INTERFACE_UNIT_CLK(gclk[3]),
        .USER_BREAK_UNIT_CLK(gclk[2]), .CACHE_CLK(gclk[1]), .USER_MEMORY_CLK(gclk[0]));
    pdc_unit_model i_pdc_unit_model (.gclk(gclk), .edges(edges), .glitches(glitches));
    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Read-back value: only the defined control bits survive a write
    function automatic logic [7:0] masked(input logic [7:0] ad, input logic [7:0] dt);
        return dt & ((ad == A1) ? PDC_MASK_MODULE_CLOCK_STOP_A : PDC_MASK_STANDBY_CONTROL);
    endfunction
    task automatic wb(input logic we, input logic [7:0] ad, dt, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: ad, dat: {24'h0, dt}};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o;
        `CHK(ack, 1'b1)
        req <= '0;
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        wb(1'b0, ad, 8'h00, 4'hf);
        `CHK(q, {24'h0, e})
    endtask
    task automatic pulse(input bit w);
        @(posedge clk);
        if (w) wake_int <= 1'b1;
        else sleep_exec <= 1'b1;
        @(posedge clk);
        wake_int <= 1'b0;
        sleep_exec <= 1'b0;
        @(negedge clk);
    endtask
    // Sixteen cycles per window; a stopped or standby unit must see none
    task automatic gates(input logic [7:0] stop, input bit sb);
        int c0 [PDC_NUM_GATES];
        @(negedge clk);
        c0 = edges;
        repeat (16) @(negedge clk);
        for (int g = 0; g < PDC_NUM_GATES; g++)
            `CHK(edges[g] - c0[g], (stop[GBIT[g]] || sb) ? 0 : 16)
    endtask
    task wrap_up;
        if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        `CHK(1'b0, 1'b1)
        wrap_up;
    end
    // ==========================================
    // Main sequence
    initial begin
        mv = 3'h0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rdc(A0, 8'h00);
        rdc(A1, 8'h00);
        rdc(8'h0c, 8'h00);
        wb(1'b1, A0, 8'hff, 4'he);
        rdc(A0, 8'h00);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            a = r[0] ? A1 : A0;
            d = (i < 2) ? 8'hff : r[15:8];
            wb(1'b1, a, d, 4'h1);
            rdc(a, masked(a, d));
            if (r[0]) gates(d, 1'b0);
        end
        wb(1'b1, A1, 8'h00, 4'h1);
        wb(1'b1, A0, 8'h08, 4'h1);
        pulse(1'b0);
        `CHK({cpu_halt, clock_halt, periph_halt}, 3'b100)
        rdc(PDC_ADDR_POWER_STATUS, {1'b0, mv, 2'b00, PDC_SLEEP});
        gates(8'h00, 1'b0);
        pulse(1'b1);
        `CHK({cpu_halt, mode_value}, {1'b0, mv})
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            wb(1'b1, A0, i[0] ? 8'h88 : 8'h80, 4'h1);
            pulse(1'b0);
            `CHK({cpu_halt, clock_halt, periph_halt}, 3'b111)
            rdc(PDC_ADDR_POWER_STATUS, {1'b0, mv, 2'b00, PDC_STANDBY});
            gates(8'h00, 1'b1);
            @(posedge clk);
            pins <= r[2:0];
            repeat (4) @(posedge clk);
            pulse(1'b1);
            if (i[0]) mv = r[2:0];
            `CHK({clock_halt, mode_value}, {1'b0, mv})
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rdc(A0, 8'h00);
        for (int g = 0; g < PDC_NUM_GATES; g++)
            `CHK(glitches[g], 0)
        wrap_up;
    end
endmodule
